// ==== design/rsc_reset_sleep.sv ====
// Summary of operation
// - Debug fuse keeps main clock running in power-down and power-save.
// - Scan port off when disable bit written one or enable fuse unprogrammed.
// - Scan enabled but not shifting: data out left undriven.
// - Sleep instruction sleeps only when sleep enable bit is one.
// - Mode field decodes idle, noise reduction, power-down, power-save, standby.
// - Code 111 with crystal clock means extended standby.
// - Standby modes offered only with crystal or resonator clock.
// - Reset loads registers with initial values; restart at reset vector.
// - Ports return to initial state at once on any reset source.
// - After all sources inactive, fuse-selected delay stretches internal reset.
// - Five sources: power-on, pin, watchdog, brown-out, scan reset register.
// - Pin low longer than minimum width resets; shorter pulses ignored.
// - Held in reset while scan reset register holds one.
// - Power-on low asserts reset at once; recovery starts the delay.
// - Brown-out enabled and supply low asserts brown-out reset.
// - Brown-out acts only after supply low beyond minimum duration.
// - After pin release, core freed only when delay expires.
// - Watchdog one-cycle pulse; delay starts on its falling edge.
// - Bandgap on only for brown-out enable, comparator select, or ADC.
`timescale 1ns/100ps
`default_nettype none
module rsc_reset_sleep
	import rsc_pkg::*;
#(
	parameter int DELAY_W = 20
)(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire rsc_io_t io_i,
	input wire logic sleep_instr_i,
	input wire logic wake_i,
	input wire logic reset_pin_n_i,
	input wire logic power_low_i,
	input wire logic brownout_low_i,
	input wire logic watchdog_pulse_i,
	input wire logic scan_reset_i,
	input wire logic debug_enable_fuse_i,
	input wire logic scan_port_enable_fuse_i,
	input wire logic brownout_enable_fuse_i,
	input wire logic crystal_clock_i,
	input wire logic [3:0] clock_select_fuses_i,
	input wire logic comparator_bandgap_select_i,
	input wire logic adc_enable_i,
	input wire logic tap_shifting_i,
	input wire logic tap_data_i,
	output logic [7:0] rdata_o,
	output logic port_reset_o,
	output logic core_reset_o,
	output logic sleeping_o,
	output logic [2:0] sleep_mode_o,
	output logic main_clock_run_o,
	output logic scan_enable_o,
	output logic tdo_o,
	output logic tdo_oe_o,
	output logic bandgap_on_o
);
	logic [7:0] ctrl_reg, ctrl_next;
	logic scan_dis_reg, scan_dis_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [DELAY_W-1:0] delay_reg, delay_next;
	logic hold_reg, hold_next;
	logic port_rst_reg, port_rst_next;
	logic sleep_reg, sleep_next;
	logic [2:0] mode_reg, mode_next;
	logic clk_run_reg, clk_run_next;
	logic scan_en_reg, scan_en_next;
	logic tdo_reg, tdo_next;
	logic tdo_oe_reg, tdo_oe_next;
	logic bg_reg, bg_next;
	logic pin_low, pwr_low, bod_low, scan_rst;
	logic [2:0] wd_sync_reg;
	logic any_src;
	logic [2:0] sm_field;
	rsc_mode_t mode_dec;
	logic [DELAY_W-1:0] delay_len;

	rsc_filter #(.COUNT(RSC_EXT_CYCLES)) u_pin (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.async_i(~reset_pin_n_i),
		.stable_o(pin_low)
	);
	rsc_filter #(.COUNT(RSC_BOD_CYCLES)) u_bod (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.async_i(brownout_low_i & brownout_enable_fuse_i),
		.stable_o(bod_low)
	);
	rsc_filter #(.COUNT(1)) u_por (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.async_i(power_low_i),
		.stable_o(pwr_low)
	);
	rsc_filter #(.COUNT(1)) u_scan (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.async_i(scan_reset_i),
		.stable_o(scan_rst)
	);

	always_comb
	begin
		any_src = pwr_low | pin_low | bod_low | scan_rst
			| (wd_sync_reg[1] & ~wd_sync_reg[2]);
		sm_field = {ctrl_reg[RSC_SM_HI_POS], ctrl_reg[RSC_SM_LO_POS+1:RSC_SM_LO_POS]};
		// Delay length doubles per fuse step
		delay_len = DELAY_W'(1) << clock_select_fuses_i;
		case (sm_field)
			RSC_SM_IDLE: mode_dec = RSC_MODE_IDLE;
			RSC_SM_ADC: mode_dec = RSC_MODE_ADC;
			RSC_SM_PDOWN: mode_dec = RSC_MODE_PDOWN;
			RSC_SM_PSAVE: mode_dec = RSC_MODE_PSAVE;
			RSC_SM_STBY: mode_dec = crystal_clock_i ? RSC_MODE_STBY : RSC_MODE_NONE;
			RSC_SM_XSTBY: mode_dec = crystal_clock_i ? RSC_MODE_XSTBY : RSC_MODE_NONE;
			default: mode_dec = RSC_MODE_NONE;
		endcase
	end

	// Register bus group
	always_comb
	begin
		ctrl_next = ctrl_reg;
		scan_dis_next = scan_dis_reg;
		rdata_next = rdata_reg;
		if (io_i.wr && io_i.addr == RSC_PWR_CTRL_OFFSET)
		begin
			ctrl_next = io_i.wdata;
		end
		if (io_i.wr && io_i.addr == RSC_RST_STATUS_OFFSET)
		begin
			scan_dis_next = io_i.wdata[RSC_SCAN_DIS_POS];
		end
		if (io_i.rd)
		begin
			if (io_i.addr == RSC_PWR_CTRL_OFFSET)
			begin
				rdata_next = ctrl_reg;
			end
			else if (io_i.addr == RSC_RST_STATUS_OFFSET)
			begin
				rdata_next = {scan_dis_reg, 7'h00};
			end
			else
			begin
				rdata_next = 8'h00;
			end
		end
		if (any_src || hold_reg)
		begin
			ctrl_next = RSC_PWR_CTRL_RESET;
			scan_dis_next = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			ctrl_reg <= RSC_PWR_CTRL_RESET;
			scan_dis_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			scan_dis_reg <= scan_dis_next;
			rdata_reg <= rdata_next;
		end
	end

	// Reset group
	always_comb
	begin
		delay_next = delay_reg;
		hold_next = hold_reg;
		port_rst_next = any_src;
		if (any_src)
		begin
			hold_next = 1'b1;
			delay_next = '0;
		end
		else if (hold_reg)
		begin
			if (delay_reg >= delay_len - DELAY_W'(1))
			begin
				hold_next = 1'b0;
			end
			else
			begin
				delay_next = delay_reg + DELAY_W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			delay_reg <= '0;
			// Core held through the first delay
			hold_reg <= 1'b1;
			port_rst_reg <= 1'b1;
			wd_sync_reg <= 3'h0;
		end
		else
		begin
			delay_reg <= delay_next;
			hold_reg <= hold_next;
			port_rst_reg <= port_rst_next;
			wd_sync_reg <= {wd_sync_reg[1:0], watchdog_pulse_i};
		end
	end

	// Sleep group
	always_comb
	begin
		sleep_next = sleep_reg;
		mode_next = mode_reg;
		if (sleep_reg)
		begin
			if (wake_i)
			begin
				sleep_next = 1'b0;
			end
		end
		else if (sleep_instr_i && ctrl_reg[RSC_SE_POS] && mode_dec != RSC_MODE_NONE)
		begin
			sleep_next = 1'b1;
			mode_next = sm_field;
		end
		if (any_src || hold_reg)
		begin
			sleep_next = 1'b0;
		end
		clk_run_next = ~(sleep_next && (mode_next == RSC_SM_PDOWN
			|| mode_next == RSC_SM_PSAVE) && !debug_enable_fuse_i);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			sleep_reg <= 1'b0;
			mode_reg <= 3'h0;
			clk_run_reg <= 1'b1;
		end
		else
		begin
			sleep_reg <= sleep_next;
			mode_reg <= mode_next;
			clk_run_reg <= clk_run_next;
		end
	end

	// Pin and reference group
	always_comb
	begin
		scan_en_next = scan_port_enable_fuse_i & ~scan_dis_next;
		tdo_oe_next = scan_en_next & tap_shifting_i;
		// Data passes always; the enable decides
		tdo_next = tap_data_i;
		bg_next = brownout_enable_fuse_i | comparator_bandgap_select_i | adc_enable_i;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			scan_en_reg <= 1'b0;
			tdo_reg <= 1'b0;
			tdo_oe_reg <= 1'b0;
			bg_reg <= 1'b0;
		end
		else
		begin
			scan_en_reg <= scan_en_next;
			tdo_reg <= tdo_next;
			tdo_oe_reg <= tdo_oe_next;
			bg_reg <= bg_next;
		end
	end

	assign rdata_o = rdata_reg;
	assign port_reset_o = port_rst_reg;
	assign core_reset_o = hold_reg;
	assign sleeping_o = sleep_reg;
	assign sleep_mode_o = mode_reg;
	assign main_clock_run_o = clk_run_reg;
	assign scan_enable_o = scan_en_reg;
	assign tdo_o = tdo_reg;
	assign tdo_oe_o = tdo_oe_reg;
	assign bandgap_on_o = bg_reg;
endmodule // rsc_reset_sleep
`default_nettype wire

// ==== design/rsc_pkg.sv ====
package rsc_pkg;
	localparam logic [5:0] RSC_PWR_CTRL_OFFSET = 6'h35;
	localparam logic [5:0] RSC_RST_STATUS_OFFSET = 6'h34;
	localparam logic [7:0] RSC_PWR_CTRL_RESET = 8'h00;
	localparam int RSC_SE_POS = 5;
	localparam int RSC_SM_LO_POS = 3;
	localparam int RSC_SM_HI_POS = 2;
	localparam int RSC_SCAN_DIS_POS = 7;
	localparam int RSC_CLK_MHZ = 125;
	// Brown-out minimum duration in ns, rounded down to cycles
	localparam int RSC_BOD_MIN_NS = 2000;
	localparam int RSC_BOD_CYCLES = (RSC_BOD_MIN_NS * RSC_CLK_MHZ) / 1000;
	// Reset pin minimum pulse in ns
	localparam int RSC_EXT_MIN_NS = 1500;
	localparam int RSC_EXT_CYCLES = (RSC_EXT_MIN_NS * RSC_CLK_MHZ) / 1000;
	localparam logic [2:0] RSC_SM_IDLE = 3'h0;
	localparam logic [2:0] RSC_SM_ADC = 3'h1;
	localparam logic [2:0] RSC_SM_PDOWN = 3'h2;
	localparam logic [2:0] RSC_SM_PSAVE = 3'h3;
	localparam logic [2:0] RSC_SM_STBY = 3'h6;
	localparam logic [2:0] RSC_SM_XSTBY = 3'h7;

	typedef enum logic [2:0] {
		RSC_MODE_NONE,
		RSC_MODE_IDLE,
		RSC_MODE_ADC,
		RSC_MODE_PDOWN,
		RSC_MODE_PSAVE,
		RSC_MODE_STBY,
		RSC_MODE_XSTBY
	} rsc_mode_t;

	typedef struct packed {
		logic power_low;
		logic brownout_low;
		logic watchdog_pulse;
		logic scan_reset;
	} rsc_src_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [5:0] addr;
		logic [7:0] wdata;
	} rsc_io_t;
endpackage

// ==== design/rsc_filter.sv ====
`timescale 1ns/100ps
`default_nettype none
module rsc_filter
	import rsc_pkg::*;
#(
	parameter int COUNT = 4
)(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic async_i,
	output logic stable_o
);
	logic [2:0] sync_reg;
	logic [31:0] cnt_reg, cnt_next;
	logic stable_reg, stable_next;

	always_comb
	begin
		cnt_next = cnt_reg;
		stable_next = stable_reg;
		if (sync_reg[1] != sync_reg[2])
		begin
			cnt_next = 32'h0;
		end
		else if (sync_reg[2] != stable_reg)
		begin
			// Level must persist to count
			if (cnt_reg >= 32'(COUNT - 1))
			begin
				stable_next = sync_reg[2];
				cnt_next = 32'h0;
			end
			else
			begin
				cnt_next = cnt_reg + 32'h1;
			end
		end
		else
		begin
			cnt_next = 32'h0;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			sync_reg <= 3'h0;
			cnt_reg <= 32'h0;
			stable_reg <= 1'b0;
		end
		else
		begin
			sync_reg <= {sync_reg[1:0], async_i};
			cnt_reg <= cnt_next;
			stable_reg <= stable_next;
		end
	end

	assign stable_o = stable_reg;
endmodule // rsc_filter
`default_nettype wire

// ==== tb/rsc_reset_sleep_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module rsc_reset_sleep_asserts (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic sleep_instr_i,
	input wire logic power_low_i,
	input wire logic debug_enable_fuse_i,
	input wire logic scan_port_enable_fuse_i,
	input wire logic brownout_enable_fuse_i,
	input wire logic crystal_clock_i,
	input wire logic comparator_bandgap_select_i,
	input wire logic adc_enable_i,
	input wire logic port_reset_o,
	input wire logic core_reset_o,
	input wire logic sleeping_o,
	input wire logic [2:0] sleep_mode_o,
	input wire logic main_clock_run_o,
	input wire logic scan_enable_o,
	input wire logic bandgap_on_o
);
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);
	chk_bandgap_follow: assert property (!$past(reset_i) |-> bandgap_on_o ==
		($past(brownout_enable_fuse_i) | $past(comparator_bandgap_select_i) | $past(adc_enable_i)))
		else $error("bandgap state wrong");
	chk_scan_fuse_off: assert property (!$past(reset_i) && !$past(scan_port_enable_fuse_i)
		|-> !scan_enable_o) else $error("scan port on without fuse");
	chk_debug_clock_on: assert property (sleeping_o && debug_enable_fuse_i
		|-> main_clock_run_o) else $error("main clock stopped in debug");
	chk_sleep_cause: assert property ($rose(sleeping_o) |-> $past(sleep_instr_i))
		else $error("sleep without instruction");
	chk_no_reserved: assert property (sleeping_o |-> sleep_mode_o[2:1] != 2'b10)
		else $error("sleep in reserved mode");
	chk_standby_xtal: assert property (sleeping_o && sleep_mode_o[2:1] == 2'b11
		|-> crystal_clock_i) else $error("standby without crystal");
	chk_power_reset: assert property ($rose(power_low_i) |-> ##[1:8] port_reset_o)
		else $error("power low not resetting ports");
	chk_delay_hold: assert property ($fell(port_reset_o) |-> core_reset_o [*8])
		else $error("core reset released early");
endmodule // rsc_reset_sleep_asserts
bind rsc_reset_sleep rsc_reset_sleep_asserts i_chk (
	.clk_sys_i(clk_sys_i),
	.reset_i(reset_i),
	.sleep_instr_i(sleep_instr_i),
	.power_low_i(power_low_i),
	.debug_enable_fuse_i(debug_enable_fuse_i),
	.scan_port_enable_fuse_i(scan_port_enable_fuse_i),
	.brownout_enable_fuse_i(brownout_enable_fuse_i),
	.crystal_clock_i(crystal_clock_i),
	.comparator_bandgap_select_i(comparator_bandgap_select_i),
	.adc_enable_i(adc_enable_i),
	.port_reset_o(port_reset_o),
	.core_reset_o(core_reset_o),
	.sleeping_o(sleeping_o),
	.sleep_mode_o(sleep_mode_o),
	.main_clock_run_o(main_clock_run_o),
	.scan_enable_o(scan_enable_o),
	.bandgap_on_o(bandgap_on_o)
);
`default_nettype wire

// ==== tb/rsc_partner.sv ====
`timescale 1ns/100ps
`default_nettype none
module rsc_partner
	import rsc_pkg::*;
(
	input wire logic clk_sys_i,
	output var rsc_src_t src_o,
	output var logic reset_pin_n_o
);
	initial
	begin
		src_o = '0;
		reset_pin_n_o = 1'b1;
	end
	task automatic hold(input int s, input int n);
		rsc_src_t m;
		m = '0;
		if (s < 4)
			m[s] = 1'b1;
		src_o <= m;
		reset_pin_n_o <= s != 4;
		repeat (n) @(posedge clk_sys_i);
		src_o <= '0;
		// Pin has a pull-up, so release means high
		reset_pin_n_o <= 1'b1;
	endtask
endmodule // rsc_partner
`default_nettype wire

// ==== tb/tb_rsc_reset_sleep.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_rsc_reset_sleep
	import rsc_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	rsc_io_t io = '0;
	logic sl = 1'b0, wk = 1'b0, dbg = 1'b1, sfu = 1'b1, bfu = 1'b1, xtal = 1'b1;
	logic comparator_bandgap_select = 1'b0, adc = 1'b0, tsh = 1'b0, tda = 1'b0, rd_d = 1'b0;
	logic [3:0] cks = 4'h4;
	logic [7:0] rdata, d, exps = 8'h1f;
	logic [2:0] smode, c;
	logic prst, crst, slp, mclk, sen, tdo, toe, bg, pin_n, exp_s;
	logic [31:0] r;
	rsc_src_t src;
	logic [7:0] q[$];
	int failures = 0, n_checks = 0, seed = 32'h0cab38d0, i, k, k4, p0, prst_cnt = 0;
	int srcs[8] = '{3, 2, 1, 0, 4, 4, 2, 2};
	int lens[8] = '{8, RSC_BOD_CYCLES + 20, 1, 8, RSC_EXT_CYCLES + 20,
		RSC_EXT_CYCLES / 2, RSC_BOD_CYCLES / 2, RSC_BOD_CYCLES + 20};
	always #4 clk_sys_i = ~clk_sys_i;
	rsc_partner i_rsc_partner (.clk_sys_i, .src_o(src), .reset_pin_n_o(pin_n));
	rsc_reset_sleep #(.DELAY_W(20)) i_rsc_reset_sleep (
		.clk_sys_i, .reset_i, .io_i(io), .sleep_instr_i(sl), .wake_i(wk), .reset_pin_n_i(pin_n),
		.power_low_i(src.power_low), .brownout_low_i(src.brownout_low),
		.watchdog_pulse_i(src.watchdog_pulse), .scan_reset_i(src.scan_reset),
		.debug_enable_fuse_i(dbg), .scan_port_enable_fuse_i(sfu), .brownout_enable_fuse_i(bfu),
		.crystal_clock_i(xtal), .clock_select_fuses_i(cks), .comparator_bandgap_select_i(comparator_bandgap_select),
		.adc_enable_i(adc), .tap_shifting_i(tsh), .tap_data_i(tda), .rdata_o(rdata),
		.port_reset_o(prst), .core_reset_o(crst), .sleeping_o(slp), .sleep_mode_o(smode),
		.main_clock_run_o(mclk), .scan_enable_o(sen), .tdo_o(tdo), .tdo_oe_o(toe),
		.bandgap_on_o(bg));
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (e !== g)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		io <= '{1'b1, 1'b0, a, v};
		@(posedge clk_sys_i);
		io <= '0;
		@(posedge clk_sys_i);
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		q.push_back(e);
		io <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk_sys_i);
		io <= '0;
		@(posedge clk_sys_i);
	endtask
	// Bounded; a stuck reset counts as a mismatch
	task automatic wait_core(output int n);
		for (n = 0; n < 3000 && crst !== 1'b0; n++)
			@(posedge clk_sys_i);
		chk("core_release", 1'b0, crst);
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk_sys_i)
	begin
		if (rd_d && q.size() > 0)
			chk("rdata", q.pop_front(), rdata);
		rd_d <= io.rd;
		if (prst === 1'b1)
			prst_cnt <= prst_cnt + 1;
	end
	initial
	begin
		repeat (20000) @(posedge clk_sys_i);
		failures++;
		$display("[FAIL] watchdog expected finish seen timeout");
		test_done();
	end
	initial
	begin
		repeat (3) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		wr(RSC_PWR_CTRL_OFFSET, 8'h3c);
		rd(RSC_PWR_CTRL_OFFSET, RSC_PWR_CTRL_RESET);
		rd(6'h10, 8'h00);
		wait_core(k);
		for (i = 0; i < 8; i++)
		begin
			r = $random(seed);
			d = r[7:0] & 8'h3c;
			bfu <= i != 7;
			wr(RSC_PWR_CTRL_OFFSET, d);
			rd(RSC_PWR_CTRL_OFFSET, d);
			p0 = prst_cnt;
			i_rsc_partner.hold(srcs[i], lens[i]);
			repeat (12) @(posedge clk_sys_i);
			chk("port_reset", exps[i], prst_cnt != p0);
			wait_core(k);
			rd(RSC_PWR_CTRL_OFFSET, exps[i] ? RSC_PWR_CTRL_RESET : d);
		end
		$display("sources done");
		for (i = 4; i < 6; i++)
		begin
			cks <= i[3:0];
			i_rsc_partner.hold(3, 8);
			wait_core(k);
			if (i == 4)
				k4 = k;
		end
		chk("delay", 16'd16, 16'(k - k4));
		$display("delay done");
		for (i = 0; i < 10; i++)
		begin
			c = (i == 9) ? 3'h6 : i[2:0];
			xtal <= i < 8;
			dbg <= i != 2;
			exp_s = i != 8 && c[2:1] != 2'b10 && (c[2:1] != 2'b11 || i < 8);
			wr(RSC_PWR_CTRL_OFFSET, {2'b00, i != 8, c[1:0], c[2], 2'b00});
			sl <= 1'b1;
			@(posedge clk_sys_i);
			sl <= 1'b0;
			repeat (2) @(posedge clk_sys_i);
			chk("sleeping", exp_s, slp);
			chk("clock_run", !(exp_s && c[2:1] == 2'b01 && !dbg), mclk);
			if (exp_s)
				chk("mode", c, smode);
			wk <= 1'b1;
			@(posedge clk_sys_i);
			wk <= 1'b0;
			@(posedge clk_sys_i);
		end
		$display("sleep done");
		repeat (8)
		begin
			r = $random(seed);
			{bfu, comparator_bandgap_select, adc, tsh, tda} <= r[4:0];
			repeat (2) @(posedge clk_sys_i);
			chk("bandgap", bfu | comparator_bandgap_select | adc, bg);
			chk("tdo_oe", tsh, toe);
			chk("tdo", tda, tdo);
		end
		sfu <= 1'b0;
		tsh <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		chk("scan_en", 1'b0, sen);
		chk("tdo_oe", 1'b0, toe);
		sfu <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		chk("scan_en", 1'b1, sen);
		wr(RSC_RST_STATUS_OFFSET, 8'h80);
		repeat (2) @(posedge clk_sys_i);
		chk("scan_en", 1'b0, sen);
		rd(RSC_RST_STATUS_OFFSET, 8'h80);
		repeat (2) @(posedge clk_sys_i);
		$display("misc done");
		test_done();
	end
endmodule // tb_rsc_reset_sleep
`default_nettype wire
